// ==== src/slspl_pkg.sv ====
// Package: register map, field positions and encodings of the link status block
`default_nettype none
package slspl_pkg;
  localparam int          AddrWidth      = 10;
  localparam int          DataWidth      = 8;
  localparam int          NumLanes       = 8;
  localparam int          TestWidth      = 5;
  localparam logic [9:0]  StatusAddr     = 10'h208;
  localparam logic [9:0]  PowerDownAddr  = 10'h209;
  localparam logic [9:0]  SpareLaneAddr  = 10'h20A;
  localparam logic [7:0]  PowerDownReset = 8'h00;
  localparam logic [7:0]  SpareLaneReset = 8'h00;
  localparam int          StLinkUpBit    = 6;
  localparam int          StSyncBit      = 5;
  localparam int          StRealignBit   = 4;
  localparam int          StAlignBit     = 3;
  localparam int          StPllLockBit   = 2;
  localparam int          PdChanBBit     = 1;
  localparam int          PdChanABit     = 0;
  localparam int          SpareSerBit    = 0;
  localparam logic [7:0]  StatusW1cMask  = 8'h18;
  localparam logic [4:0]  TestNormal     = 5'h00;
  localparam logic [4:0]  TestRamp       = 5'h04;
  localparam logic [4:0]  TestTransport  = 5'h05;
endpackage : slspl_pkg
`default_nettype wire

// ==== src/slspl_lane_if.sv ====
// Interface: per-lane enable and pattern selection between lane logic and top
`default_nettype none
interface slspl_lane_if;
  logic [7:0] modeLanes;
  logic [7:0] spareLanes;
  logic       spareSerEn;
  logic       linkOn;
  logic [4:0] testSel;
  logic [7:0] laneClkEn;
  logic [7:0] serClkEn;
  logic [7:0] laneRamp;
  modport ctrl (output modeLanes, spareLanes, spareSerEn, linkOn, testSel,
                input laneClkEn, serClkEn, laneRamp);
  modport lanes (input modeLanes, spareLanes, spareSerEn, linkOn, testSel,
                 output laneClkEn, serClkEn, laneRamp);
endinterface : slspl_lane_if
`default_nettype wire

// ==== src/slspl_lane_ctrl.sv ====
// Lane logic: clock, serializer and ramp selection for the link A lanes
`default_nettype none
module slspl_lane_ctrl
(
  slspl_lane_if.lanes lane
);
  logic [7:0] wantLane;
  logic [7:0] serCand;
  logic [7:0] prefixOk;
  logic [4:0] testNow;

  always_comb
  begin
    wantLane = (lane.modeLanes | lane.spareLanes) & {8{lane.linkOn}};
    serCand  = lane.modeLanes | (lane.spareLanes & {8{lane.spareSerEn}});
    serCand  = serCand & {8{lane.linkOn}};
    prefixOk[0] = 1'b1;
    for (int i = 1; i < 8; i++)
    begin
      prefixOk[i] = prefixOk[i-1] & serCand[i-1];
    end
    testNow = lane.testSel;
    lane.laneClkEn = wantLane;
    lane.serClkEn  = serCand & prefixOk;
    for (int i = 0; i < 8; i++)
    begin
      // Spare-only lanes have no payload in normal or transport mode
      lane.laneRamp[i] = lane.spareLanes[i] & ~lane.modeLanes[i] & lane.linkOn
                         & ((testNow == slspl_pkg::TestNormal)
                            | (testNow == slspl_pkg::TestTransport));
    end
  end
endmodule : slspl_lane_ctrl
`default_nettype wire

// ==== src/slspl_top.sv ====
// Top: link status, channel power-down and spare lane control registers
// Functional notes
// - Status bit 6 shows link up
// - Status bit 5 follows sync input level
// - Bit 4 set on realign, write-one clears
// - Bit 3 set first SYSREF after enable
// - Status bit 2 shows serializer PLL lock
// - Power-down bit 1 kills channel B
// - Power-down bit 0 kills channel A
// - Both bits down: whole link powered down
// - B disabled on shared link: slots undefined
// - Spare bits 7:1 enable lane clocks
// - Bit 0 also enables spare serializers
// - Spare lanes follow mode and test pattern
// - Spare-only lane ramps for test 0/5
// - Spare lanes need enabled, powered link
// - Serializer clocked only if lower lanes on
`default_nettype none
module slspl_top
(
  input  wire logic       sys_clk,
  input  wire logic       reset,
  input  wire logic [9:0] regAddr,
  input  wire logic [7:0] regWrData,
  input  wire logic       regWrStb,
  input  wire logic       regRdStb,
  output var  logic [7:0] regRdData,
  input  wire logic       syncN,
  input  wire logic       sysrefEvt,
  input  wire logic       sysrefShift,
  input  wire logic       pllLockRaw,
  input  wire logic       linkUpRaw,
  input  wire logic       link_enable,
  input  wire logic [7:0] link_mode_select,
  input  wire logic [4:0] link_test_pattern,
  input  wire logic       modeDualOnA,
  output var  logic       chanAPowerDown,
  output var  logic       chanBPowerDown,
  output var  logic       linkPowerDown,
  output var  logic       chanBSlotsUndefined,
  output var  logic [7:0] laneClkEn,
  output var  logic [7:0] serClkEn,
  output var  logic [7:0] laneRamp
);
  typedef struct packed {
    logic [1:0] syncMeta;
    logic       evtPrev;
    logic       shiftPrev;
    logic [1:0] lockMeta;
    logic [1:0] upMeta;
    logic [1:0] evtMeta;
    logic [1:0] shiftMeta;
    logic       enPrev;
    logic       waitFirst;
    logic       realigned;
    logic       phase_established_flag;
    logic [1:0] powerDown;
    logic [7:0] spareReg;
    logic [7:0] rdData;
    logic       pdA;
    logic       pdB;
    logic       pdLink;
    logic       bUndef;
    logic [7:0] laneClk;
    logic [7:0] serClk;
    logic [7:0] ramp;
  } slspl_state_s;

  slspl_state_s s_q;
  slspl_state_s s_d;
  slspl_lane_if lane ();

  logic [7:0] statusView;
  logic       evtEdge;
  logic       shiftEdge;
  logic       wrStatus;

  // Lane selection from the link mode; power-down of both channels drops the link
  assign lane.modeLanes  = link_mode_select;
  assign lane.spareLanes = {s_q.spareReg[7:1], 1'b0};
  assign lane.spareSerEn = s_q.spareReg[slspl_pkg::SpareSerBit];
  assign lane.linkOn     = link_enable & ~(s_q.powerDown[0] & s_q.powerDown[1]);
  assign lane.testSel    = link_test_pattern;

  slspl_lane_ctrl u_lanes
  (
    .lane (lane)
  );

  always_comb
  begin
    s_d = s_q;
    // Two-stage synchronisers on every asynchronous status source
    s_d.syncMeta  = {s_q.syncMeta[0], syncN};
    s_d.lockMeta  = {s_q.lockMeta[0], pllLockRaw};
    s_d.upMeta    = {s_q.upMeta[0], linkUpRaw};
    s_d.evtMeta   = {s_q.evtMeta[0], sysrefEvt};
    s_d.shiftMeta = {s_q.shiftMeta[0], sysrefShift};
    s_d.evtPrev   = s_q.evtMeta[1];
    s_d.shiftPrev = s_q.shiftMeta[1];
    evtEdge   = s_q.evtMeta[1] & ~s_q.evtPrev;
    shiftEdge = s_q.shiftMeta[1] & ~s_q.shiftPrev;
    wrStatus  = regWrStb & (regAddr == slspl_pkg::StatusAddr);

    statusView = 8'h00;
    statusView[slspl_pkg::StLinkUpBit]  = s_q.upMeta[1];
    statusView[slspl_pkg::StSyncBit]    = s_q.syncMeta[1];
    statusView[slspl_pkg::StRealignBit] = s_q.realigned;
    statusView[slspl_pkg::StAlignBit]   = s_q.phase_established_flag;
    statusView[slspl_pkg::StPllLockBit] = s_q.lockMeta[1];

    // Write-one clears; a same-cycle event wins
    if (wrStatus && regWrData[slspl_pkg::StRealignBit])
    begin
      s_d.realigned = 1'b0;
    end
    if (shiftEdge)
    begin
      s_d.realigned = 1'b1;
    end
    if (wrStatus && regWrData[slspl_pkg::StAlignBit])
    begin
      s_d.phase_established_flag = 1'b0;
    end
    s_d.enPrev = link_enable;
    if (link_enable && !s_q.enPrev)
    begin
      s_d.waitFirst = 1'b1;
    end
    else if (!link_enable)
    begin
      s_d.waitFirst = 1'b0;
    end
    if (evtEdge && s_q.waitFirst && link_enable)
    begin
      s_d.phase_established_flag   = 1'b1;
      s_d.waitFirst = 1'b0;
    end

    // Writes while the link runs are taken; the host keeps the ordering
    if (regWrStb && regAddr == slspl_pkg::PowerDownAddr)
    begin
      s_d.powerDown = regWrData[1:0];
    end
    if (regWrStb && regAddr == slspl_pkg::SpareLaneAddr)
    begin
      s_d.spareReg = regWrData;
    end

    s_d.rdData = 8'h00;
    if (regRdStb)
    begin
      unique case (regAddr)
        slspl_pkg::StatusAddr:    s_d.rdData = statusView;
        slspl_pkg::PowerDownAddr: s_d.rdData = {6'h00, s_q.powerDown};
        slspl_pkg::SpareLaneAddr: s_d.rdData = s_q.spareReg;
        default:                  s_d.rdData = 8'h00;
      endcase
    end

    s_d.pdA    = s_q.powerDown[slspl_pkg::PdChanABit];
    s_d.pdB    = s_q.powerDown[slspl_pkg::PdChanBBit];
    s_d.pdLink = s_q.powerDown[0] & s_q.powerDown[1];
    // Shared link keeps running; B slots carry no valid samples
    s_d.bUndef = modeDualOnA & s_q.powerDown[slspl_pkg::PdChanBBit]
                 & ~s_q.powerDown[slspl_pkg::PdChanABit];
    s_d.laneClk = lane.laneClkEn;
    s_d.serClk  = lane.serClkEn;
    s_d.ramp    = lane.laneRamp;
  end

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      s_q <= '0;
      s_q.powerDown <= slspl_pkg::PowerDownReset[1:0];
      s_q.spareReg  <= slspl_pkg::SpareLaneReset;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign regRdData           = s_q.rdData;
  assign chanAPowerDown      = s_q.pdA;
  assign chanBPowerDown      = s_q.pdB;
  assign linkPowerDown       = s_q.pdLink;
  assign chanBSlotsUndefined = s_q.bUndef;
  assign laneClkEn           = s_q.laneClk;
  assign serClkEn            = s_q.serClk;
  assign laneRamp            = s_q.ramp;
endmodule : slspl_top
`default_nettype wire

// ==== verif/slspl_properties.sv ====
// Checker: port-level properties of the link status block
`default_nettype none
module slspl_properties
(
  input wire logic       sys_clk,
  input wire logic       reset,
  input wire logic [9:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic       regWrStb,
  input wire logic       regRdStb,
  input wire logic [7:0] regRdData,
  input wire logic       linkUpRaw,
  input wire logic       link_enable,
  input wire logic [7:0] link_mode_select,
  input wire logic [4:0] link_test_pattern,
  input wire logic       chanAPowerDown,
  input wire logic       chanBPowerDown,
  input wire logic       linkPowerDown,
  input wire logic [7:0] laneClkEn,
  input wire logic [7:0] serClkEn,
  input wire logic [7:0] laneRamp
);
  timeunit 1ns;
  timeprecision 1ps;
  // Shadow registers; reserved bits dropped
  logic [1:0] pdQ;
  logic [7:0] spQ, spLn, lnE, serE, rmpE;
  logic       on;
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      pdQ <= 2'h0;
      spQ <= 8'h00;
    end
    else if (regWrStb && regAddr == slspl_pkg::PowerDownAddr)
      pdQ <= regWrData[1:0];
    else if (regWrStb && regAddr == slspl_pkg::SpareLaneAddr)
      spQ <= regWrData;
  end
  always_comb
  begin
    on = link_enable & ~&pdQ;
    spLn = {spQ[7:1], 1'b0};
    lnE = (link_mode_select | spLn) & {8{on}};
    rmpE = spLn & ~link_mode_select & {8{on && (link_test_pattern == slspl_pkg::TestNormal
           || link_test_pattern == slspl_pkg::TestTransport)}};
    serE[0] = link_mode_select[0] & on;
    for (int i = 1; i < 8; i++)
      serE[i] = serE[i-1] & (link_mode_select[i] | spLn[i] & spQ[0]);
  end
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (reset);
  sequence upSteady;
    $stable(linkUpRaw) [*4];
  endsequence
  sequence stRead;
    regRdStb && regAddr == slspl_pkg::StatusAddr;
  endsequence
  pd_outputs_a: assert property ({chanBPowerDown, chanAPowerDown} == $past(pdQ))
    else $error("channel power-down outputs wrong");
  link_pd_a: assert property (linkPowerDown == (&$past(pdQ)))
    else $error("link power-down wrong");
  lane_clk_a: assert property (laneClkEn == $past(lnE))
    else $error("lane clock enables wrong");
  ser_clk_a: assert property (serClkEn == $past(serE))
    else $error("serializer enables wrong");
  ser_prefix_a: assert property ((serClkEn & (serClkEn + 8'h01)) == 8'h00)
    else $error("serializer enable gap");
  lane_ramp_a: assert property (laneRamp == $past(rmpE))
    else $error("ramp lanes wrong");
  pd_read_a: assert property (regRdStb && regAddr == slspl_pkg::PowerDownAddr |=>
    regRdData == {6'h00, $past(pdQ)}) else $error("power-down read wrong");
  link_up_a: assert property (upSteady ##0 stRead |=> regRdData[6] == $past(linkUpRaw))
    else $error("link up status wrong");
endmodule : slspl_properties
bind slspl_top slspl_properties i_props (.*);
`default_nettype wire

// ==== verif/slspl_rx_model.sv ====
// Model of the link receiver: SYNC~ and SYSREF events
`default_nettype none
module slspl_rx_model #(parameter int Lat = 3)
(
  input  wire logic sys_clk,
  input  wire logic ready,
  input  wire logic pulse,
  output var  logic syncN,
  output var  logic sysrefEvt
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = 0;
  // Holds SYNC~ asserted (low) until ready has been high for more than Lat cycles
  always @(posedge sys_clk)
  begin
    cnt <= ready ? cnt + 1 : 0;
    syncN <= ready && cnt >= Lat;
    sysrefEvt <= pulse;
  end
endmodule : slspl_rx_model
`default_nettype wire

// ==== verif/test_serial_link_status_power_lanes.sv ====
// Bench: registers, power-down, lanes and status of the link status block
`default_nettype none
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin error_cnt++; \
  $display("mismatch %s expected %h seen %h", nm, ex, got); end end
module test_serial_link_status_power_lanes;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 0, reset = 1, regWrStb = 0, regRdStb = 0, sysrefShift = 0, pllLockRaw = 0;
  logic linkUpRaw = 0, link_enable = 0, modeDualOnA = 0, rxReady = 0, rxPulse = 0;
  logic syncN, sysrefEvt, chanAPowerDown, chanBPowerDown, linkPowerDown, chanBSlotsUndefined;
  logic [9:0] regAddr = 10'h000;
  logic [7:0] regWrData = 8'h00, link_mode_select = 8'h01, d, regRdData;
  logic [7:0] laneClkEn, serClkEn, laneRamp;
  logic [3:0] po;
  logic [4:0] link_test_pattern = 5'h00;
  int error_cnt = 0, checks = 0;
  slspl_top i_dut (.*);
  slspl_rx_model i_rx (.sys_clk, .ready(rxReady), .pulse(rxPulse), .syncN, .sysrefEvt);
  initial
  begin
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic wr(input logic [9:0] a, input logic [7:0] v);
    @(posedge sys_clk);
    {regAddr, regWrData, regWrStb} <= {a, v, 1'b1};
    @(posedge sys_clk);
    regWrStb <= 1'b0;
  endtask : wr
  task automatic rd(input logic [9:0] a);
    @(posedge sys_clk);
    {regAddr, regRdStb} <= {a, 1'b1};
    @(posedge sys_clk);
    regRdStb <= 1'b0;
    @(posedge sys_clk);
    d = regRdData;
  endtask : rd
  task automatic t_pd;
    logic [7:0] pv [3] = '{8'hFE, 8'h01, 8'h03};
    logic [3:0] px [3] = '{4'h9, 4'h4, 4'hE};
    rd(slspl_pkg::SpareLaneAddr);
    `CHK("spare reset", slspl_pkg::SpareLaneReset, d)
    wr(10'h3FF, 8'hFF);
    rd(10'h3FF);
    `CHK("unmapped", 8'h00, d)
    modeDualOnA <= 1'b1; // calibration offset lives outside this block
    for (int i = 0; i < 3; i++)
    begin
      wr(slspl_pkg::PowerDownAddr, pv[i]);
      rd(slspl_pkg::PowerDownAddr);
      `CHK("pd read", pv[i] & 8'h03, d)
      po = {chanBPowerDown, chanAPowerDown, linkPowerDown, chanBSlotsUndefined};
      `CHK("pd outs", px[i], po)
    end
    $display("test power-down done");
  endtask : t_pd
  task automatic lanes(input logic [7:0] sp, input logic [4:0] tp, input logic [1:0] pd,
                       input logic [23:0] ex);
    @(posedge sys_clk);
    link_enable <= 1'b0;
    wr(slspl_pkg::SpareLaneAddr, sp);
    wr(slspl_pkg::PowerDownAddr, {6'h00, pd});
    {link_test_pattern, link_enable} <= {tp, 1'b1};
    rd(slspl_pkg::SpareLaneAddr);
    `CHK("spare read", sp, d)
    `CHK("lane outs", ex, {laneClkEn, serClkEn, laneRamp})
  endtask : lanes
  task automatic pulse(input logic shift);
    @(posedge sys_clk);
    {sysrefShift, rxPulse} <= {shift, ~shift};
    repeat (3) @(posedge sys_clk);
    {sysrefShift, rxPulse} <= 2'b00;
    rd(slspl_pkg::StatusAddr);
  endtask : pulse
  task automatic t_status;
    {linkUpRaw, pllLockRaw, rxReady} <= 3'b111;
    for (int i = 0; i < 20 && syncN !== 1'b1; i++)
      @(posedge sys_clk);
    if (syncN !== 1'b1)
    begin
      error_cnt++;
      test_done();
    end
    repeat (4) @(posedge sys_clk);
    rd(slspl_pkg::StatusAddr);
    `CHK("status", 8'h64, d)
    pulse(1'b1);
    `CHK("realigned", 8'h74, d)
    wr(slspl_pkg::StatusAddr, 8'h10);
    pulse(1'b0);
    `CHK("phase_established_flag", 8'h6C, d)
    wr(slspl_pkg::StatusAddr, 8'hEF);
    pulse(1'b0);
    `CHK("phase_established_flag once", 8'h64, d)
    {linkUpRaw, rxReady} <= 2'b00;
    repeat (6) @(posedge sys_clk);
    rd(slspl_pkg::StatusAddr);
    `CHK("status low", 8'h04, d)
    $display("test status done");
  endtask : t_status
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : test_done
  initial
  begin
    repeat (12) @(posedge sys_clk);
    reset <= 1'b0;
    t_pd();
    lanes(8'h0F, 5'h00, 2'h0, 24'h0F0F0E);
    lanes(8'h0E, 5'h05, 2'h0, 24'h0F010E);
    lanes(8'h15, 5'h04, 2'h0, 24'h150100);
    lanes(8'hFF, 5'h01, 2'h1, 24'hFFFF00);
    lanes(8'hFF, 5'h00, 2'h3, 24'h000000); // both bits only to reach
    $display("test lanes done");
    t_status();
    test_done();
  end
endmodule : test_serial_link_status_power_lanes
`default_nettype wire
